//--- core/sport_pkg.sv
/*
 * Constants, register map and carrier types of the sport serial data port.
 * Assumes one 10 MHz system clock and a plain register port.
 */
package sport_pkg;
    // Clock and bit timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int BIT_PERIOD_NS = 800;
    localparam int BIT_HALF_RAW = (BIT_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int BIT_HALF_CYC = (BIT_HALF_RAW < 1) ? 1 : BIT_HALF_RAW;
    localparam logic [7:0] BIT_HALF_LAST = 8'(BIT_HALF_CYC - 1);
    localparam logic [3:0] EXT_CLK_HALF_LAST = 4'h1;

    // Register offsets
    localparam logic [9:0] ADDR_DATA_PATH_CTRL = 10'h126;
    localparam logic [9:0] ADDR_PIN_FUNC_CFG = 10'h3FA;
    localparam logic [9:0] ADDR_RADIO_STATE = 10'h3F0;
    localparam logic [9:0] ADDR_MOD_CFG = 10'h3F1;
    localparam logic [9:0] ADDR_STATUS = 10'h3F2;

    // Field positions
    localparam int DATA_MODE_LSB = 0;
    localparam int GAUSS_BIT = 0;
    localparam int STAT_CMD_DONE = 0;
    localparam int STAT_DET_LEVEL = 1;
    localparam int STAT_PRE_SEEN = 2;
    localparam int STAT_FW_LSB = 4;
    localparam int IRQ0_PREAMBLE_BIT = 0;
    localparam int IRQ0_SYNC_BIT = 1;
    localparam logic [7:0] IRQ0_SPORT_MASK = 8'h03;

    // Data-path modes
    localparam logic [1:0] DATA_MODE_PACKET = 2'h0;
    localparam logic [1:0] DATA_MODE_SPORT_PRE = 2'h1;
    localparam logic [1:0] DATA_MODE_SPORT_SYNC = 2'h2;

    // Pin configuration range
    localparam logic [7:0] PIN_CFG_FIRST = 8'hA0;
    localparam logic [7:0] PIN_CFG_LAST = 8'hA8;

    // Reset values
    localparam logic [7:0] RST_DATA_PATH_CTRL = 8'h00;
    localparam logic [7:0] RST_PIN_FUNC_CFG = 8'hA0;
    localparam logic [7:0] RST_MOD_CFG = 8'h00;

    // Radio state commands
    localparam logic [1:0] CMD_ON = 2'h0;
    localparam logic [1:0] CMD_TX = 2'h1;
    localparam logic [1:0] CMD_RX = 2'h2;

    typedef enum logic [2:0] {
        ST_ON = 3'b001,
        ST_TX = 3'b010,
        ST_RX = 3'b100
    } radio_state_e;

    // Detection pin and auxiliary pin functions
    typedef enum logic [1:0] {
        DET_NONE = 2'h0,
        DET_LEVEL = 2'h1,
        DET_STROBE = 2'h2
    } det_kind_e;

    typedef enum logic [1:0] {
        AUX_NONE = 2'h0,
        AUX_XTAL = 2'h1,
        AUX_EXT_CLK = 2'h2
    } aux_kind_e;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } reg_req_s;

    typedef struct packed {
        logic val;
        logic oe;
    } pin_drive_s;
endpackage : sport_pkg

//--- core/sport_port.sv
/*
 * Sport serial data port: bit clock generation, raw transmit and receive
 * paths, detection pin, auxiliary pin and reduced interrupt routing.
 * Assumes demodulator, detector and interrupt sources on the system clock;
 * transmit data and auxiliary pin arrive from outside and are synchronised.
 */

module sport_port (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire sport_pkg::reg_req_s i_req,
    output logic [7:0] o_rdata,
    input wire logic i_tx_serial,
    input wire logic i_aux,
    input wire logic i_rx_bit,
    input wire logic i_preamble_det,
    input wire logic i_sync_det,
    input wire logic i_pkt_tx_bit,
    input wire logic [7:0] i_irq_src0,
    input wire logic [7:0] i_irq_src1,
    output sport_pkg::pin_drive_s o_rx_serial,
    output sport_pkg::pin_drive_s o_bit_clk,
    output sport_pkg::pin_drive_s o_detect,
    output sport_pkg::pin_drive_s o_aux,
    output logic o_xtal_clk,
    output logic o_mod_bit,
    output logic o_sport_active,
    output logic o_cmd_done,
    output logic o_irq_general
);
    import sport_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] pin_cfg;
        logic [7:0] mod_cfg;
        radio_state_e state;
        logic cmd_done;
        logic cmd_done_pulse;
        logic [7:0] rdata;
        logic [7:0] half_cnt;
        logic bclk;
        logic tx_s1;
        logic tx_s2;
        logic aux_s1;
        logic aux_s2;
        logic [1:0] lat;
        logic mod_bit;
        logic rx_out;
        logic pre_seen;
        logic det_level;
        logic det_strobe;
        logic armed;
        logic [2:0] bit_idx;
        logic [3:0] ext_cnt;
        logic ext_clk;
    } state_s;

    state_s s;
    state_s next_s;

    function automatic det_kind_e det_kind(input logic [7:0] cfg);
        logic [7:0] idx;
        idx = cfg - PIN_CFG_FIRST;
        if (cfg < PIN_CFG_FIRST || cfg > PIN_CFG_LAST) begin
            return DET_NONE;
        end
        case (idx % 8'h03)
            8'h01: return DET_LEVEL;
            8'h02: return DET_STROBE;
            default: return DET_NONE;
        endcase
    endfunction : det_kind

    function automatic aux_kind_e aux_kind(input logic [7:0] cfg);
        logic [7:0] idx;
        idx = cfg - PIN_CFG_FIRST;
        if (cfg < PIN_CFG_FIRST || cfg > PIN_CFG_LAST) begin
            return AUX_NONE;
        end
        case (idx / 8'h03)
            8'h01: return AUX_XTAL;
            8'h02: return AUX_EXT_CLK;
            default: return AUX_NONE;
        endcase
    endfunction : aux_kind

    logic [1:0] data_mode;
    logic sport;
    logic in_tx;
    logic in_rx;
    logic clk_run;
    logic half_wrap;
    logic bit_rise;
    logic bit_fall;
    logic det_trigger;
    det_kind_e dk;
    aux_kind_e ak;
    logic [1:0] fw_code;

    always_comb begin
        data_mode = s.ctrl[DATA_MODE_LSB +: 2];
        sport = (data_mode == DATA_MODE_SPORT_PRE) || (data_mode == DATA_MODE_SPORT_SYNC);
        in_tx = (s.state == ST_TX);
        in_rx = (s.state == ST_RX);
        clk_run = sport && (in_tx || in_rx);
        half_wrap = clk_run && (s.half_cnt == BIT_HALF_LAST);
        bit_rise = half_wrap && !s.bclk;
        bit_fall = half_wrap && s.bclk;
        dk = det_kind(s.pin_cfg);
        ak = aux_kind(s.pin_cfg);
        if (data_mode == DATA_MODE_SPORT_PRE) begin
            det_trigger = i_preamble_det;
        end else if (data_mode == DATA_MODE_SPORT_SYNC) begin
            det_trigger = i_sync_det;
        end else begin
            det_trigger = 1'b0;
        end
        case (s.state)
            ST_TX: fw_code = CMD_TX;
            ST_RX: fw_code = CMD_RX;
            default: fw_code = CMD_ON;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.cmd_done_pulse = 1'b0;
        next_s.rdata = 8'h00;

        // Pin synchronisers
        next_s.tx_s1 = i_tx_serial;
        next_s.tx_s2 = s.tx_s1;
        next_s.aux_s1 = i_aux;
        next_s.aux_s2 = s.aux_s1;

        // Register reads
        if (i_req.re) begin
            case (i_req.addr)
                ADDR_DATA_PATH_CTRL: next_s.rdata = s.ctrl;
                ADDR_PIN_FUNC_CFG: next_s.rdata = s.pin_cfg;
                ADDR_RADIO_STATE: next_s.rdata = {6'h00, fw_code};
                ADDR_MOD_CFG: next_s.rdata = s.mod_cfg;
                ADDR_STATUS: begin
                    next_s.rdata = {2'h0, fw_code, 1'b0, s.pre_seen, s.det_level,
                        s.cmd_done};
                end
                default: next_s.rdata = 8'h00;
            endcase
        end

        // Register writes
        if (i_req.we) begin
            case (i_req.addr)
                ADDR_DATA_PATH_CTRL: next_s.ctrl = i_req.wdata;
                ADDR_PIN_FUNC_CFG: next_s.pin_cfg = i_req.wdata;
                ADDR_MOD_CFG: next_s.mod_cfg = i_req.wdata;
                ADDR_STATUS: begin
                    if (i_req.wdata[STAT_CMD_DONE]) begin
                        next_s.cmd_done = 1'b0;
                    end
                end
                ADDR_RADIO_STATE: begin
                    // State left only by command
                    case (i_req.wdata[1:0])
                        CMD_TX: next_s.state = ST_TX;
                        CMD_RX: next_s.state = ST_RX;
                        default: next_s.state = ST_ON;
                    endcase
                    next_s.cmd_done = 1'b1;
                    next_s.cmd_done_pulse = 1'b1;
                    next_s.half_cnt = 8'h00;
                    next_s.bclk = 1'b0;
                    next_s.lat = 2'h0;
                    next_s.pre_seen = 1'b0;
                    next_s.det_level = 1'b0;
                    next_s.det_strobe = 1'b0;
                    next_s.armed = 1'b0;
                    next_s.bit_idx = 3'h0;
                end
                default: begin
                end
            endcase
        end

        if (!(i_req.we && i_req.addr == ADDR_RADIO_STATE)) begin
            // Bit clock divider
            if (clk_run) begin
                if (half_wrap) begin
                    next_s.half_cnt = 8'h00;
                    next_s.bclk = !s.bclk;
                end else begin
                    next_s.half_cnt = s.half_cnt + 8'h01;
                end
            end else begin
                next_s.half_cnt = 8'h00;
                next_s.bclk = 1'b0;
            end

            // Transmit sampling on rising edge
            if (in_tx && bit_rise) begin
                next_s.lat = {s.lat[0], s.tx_s2};
                if (s.mod_cfg[GAUSS_BIT]) begin
                    next_s.mod_bit = s.lat[1];
                end else begin
                    next_s.mod_bit = s.tx_s2;
                end
            end

            // Receive side
            if (in_rx) begin
                if (i_preamble_det) begin
                    next_s.pre_seen = 1'b1;
                end
                if (bit_fall) begin
                    next_s.rx_out = i_rx_bit;
                    if (s.armed) begin
                        next_s.det_strobe = (s.bit_idx == 3'h0);
                        next_s.bit_idx = s.bit_idx + 3'h1;
                    end
                end
                if (det_trigger && sport) begin
                    next_s.det_level = 1'b1;
                    next_s.armed = 1'b1;
                    next_s.bit_idx = 3'h0;
                end
            end else begin
                next_s.pre_seen = 1'b0;
                next_s.det_level = 1'b0;
                next_s.det_strobe = 1'b0;
                next_s.armed = 1'b0;
                next_s.bit_idx = 3'h0;
            end
        end

        // External processor clock divider
        if (ak == AUX_EXT_CLK) begin
            if (s.ext_cnt == EXT_CLK_HALF_LAST) begin
                next_s.ext_cnt = 4'h0;
                next_s.ext_clk = !s.ext_clk;
            end else begin
                next_s.ext_cnt = s.ext_cnt + 4'h1;
            end
        end else begin
            next_s.ext_cnt = 4'h0;
            next_s.ext_clk = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s.ctrl <= RST_DATA_PATH_CTRL;
            s.pin_cfg <= RST_PIN_FUNC_CFG;
            s.mod_cfg <= RST_MOD_CFG;
            s.state <= ST_ON;
            s.cmd_done <= 1'b0;
            s.cmd_done_pulse <= 1'b0;
            s.rdata <= 8'h00;
            s.half_cnt <= 8'h00;
            s.bclk <= 1'b0;
            s.tx_s1 <= 1'b0;
            s.tx_s2 <= 1'b0;
            s.aux_s1 <= 1'b0;
            s.aux_s2 <= 1'b0;
            s.lat <= 2'h0;
            s.mod_bit <= 1'b0;
            s.rx_out <= 1'b0;
            s.pre_seen <= 1'b0;
            s.det_level <= 1'b0;
            s.det_strobe <= 1'b0;
            s.armed <= 1'b0;
            s.bit_idx <= 3'h0;
            s.ext_cnt <= 4'h0;
            s.ext_clk <= 1'b0;
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    // Pin and output drive
    always_comb begin
        o_rdata = s.rdata;
        o_sport_active = sport;
        o_cmd_done = s.cmd_done_pulse;

        o_bit_clk.val = s.bclk;
        o_bit_clk.oe = clk_run;

        o_rx_serial.val = s.rx_out;
        if (dk == DET_NONE) begin
            o_rx_serial.oe = sport && in_rx;
        end else begin
            o_rx_serial.oe = sport && in_rx && s.pre_seen;
        end

        case (dk)
            DET_LEVEL: begin
                o_detect.val = s.det_level;
                o_detect.oe = sport;
            end
            DET_STROBE: begin
                o_detect.val = s.det_strobe;
                o_detect.oe = sport;
            end
            default: begin
                o_detect.val = 1'b0;
                o_detect.oe = 1'b0;
            end
        endcase

        o_aux.val = s.ext_clk;
        o_aux.oe = sport && (ak == AUX_EXT_CLK);
        o_xtal_clk = (ak == AUX_XTAL) ? s.aux_s2 : 1'b0;

        // Modulator source
        if (sport) begin
            o_mod_bit = s.mod_bit;
        end else begin
            o_mod_bit = i_pkt_tx_bit;
        end

        // General interrupt pin
        if (sport) begin
            o_irq_general = (|i_irq_src1) || (|(i_irq_src0 & IRQ0_SPORT_MASK));
        end else begin
            o_irq_general = (|i_irq_src1) || (|i_irq_src0);
        end
    end
endmodule : sport_port

//--- sim/sport_port_monitor.sv
/*
 * Concurrent checks on the sport port pins and register port.
 * Assumes the sport_port top module; bound at the foot of this file.
 */
module sport_port_monitor (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire sport_pkg::reg_req_s i_req,
    input wire logic i_pkt_tx_bit,
    input wire logic [7:0] i_irq_src0,
    input wire logic [7:0] i_irq_src1,
    input wire sport_pkg::pin_drive_s o_rx_serial,
    input wire sport_pkg::pin_drive_s o_bit_clk,
    input wire sport_pkg::pin_drive_s o_detect,
    input wire logic o_mod_bit,
    input wire logic o_sport_active,
    input wire logic o_cmd_done,
    input wire logic o_irq_general
);
    timeunit 1ns;
    timeprecision 100ps;
    import sport_pkg::*;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst || !i_ce);
    a_clk_sport_only: assert property (o_bit_clk.oe |-> o_sport_active)
        else $error("bit clock driven outside sport mode");
    a_packet_mod_path: assert property (!o_sport_active |-> o_mod_bit == i_pkt_tx_bit)
        else $error("packet bit not on modulator");
    a_irq_reduced_set: assert property (o_sport_active |->
        o_irq_general == ((|i_irq_src1) || (|(i_irq_src0 & IRQ0_SPORT_MASK))))
        else $error("general interrupt set wrong");
    a_done_after_write: assert property (
        i_req.we && i_req.addr == ADDR_RADIO_STATE |=> o_cmd_done)
        else $error("no done pulse after state write");
    a_done_has_cause: assert property (o_cmd_done |-> $past(i_req.we))
        else $error("done pulse without write");
    a_clk_high_half: assert property ($rose(o_bit_clk.val) |-> ##4 !o_bit_clk.val)
        else $error("bit clock high phase wrong");
    a_rx_still_high: assert property (
        o_bit_clk.val && $past(o_bit_clk.val) |-> $stable(o_rx_serial.val))
        else $error("receive data moved while clock high");
    a_rx_needs_clock: assert property (o_rx_serial.oe |-> o_bit_clk.oe)
        else $error("receive data without clock");
    a_tx_on_rise: assert property (o_sport_active && $past(o_sport_active) &&
        !$past(i_req.we) && $changed(o_mod_bit) |->
        o_bit_clk.val && !$past(o_bit_clk.val))
        else $error("modulator bit moved off a rise");
    a_det_sport_only: assert property (o_detect.oe |-> o_sport_active)
        else $error("detection pin driven in packet mode");
    c_detect: cover property ($rose(o_detect.val));
    c_rx_on: cover property ($rose(o_rx_serial.oe));
    c_done: cover property (o_cmd_done);
endmodule : sport_port_monitor

bind sport_port sport_port_monitor sport_port_monitor_i (
    .i_clk_sys, .i_rst, .i_ce, .i_req, .i_pkt_tx_bit, .i_irq_src0, .i_irq_src1,
    .o_rx_serial, .o_bit_clk, .o_detect, .o_mod_bit, .o_sport_active,
    .o_cmd_done, .o_irq_general
);

//--- sim/sport_host_model.sv
/*
 * Host serial port model: shifts a preamble byte and a data byte out on
 * bit clock falls, and a byte in on rises.
 * Assumes the bit clock pin of the port, sampled on the system clock.
 */
module sport_host_model (
    input wire logic i_clk_sys,
    input wire sport_pkg::pin_drive_s i_bit_clk,
    input wire sport_pkg::pin_drive_s i_rx,
    input wire logic [7:0] i_tx_byte,
    output logic o_tx,
    output logic [7:0] o_rx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    import sport_pkg::*;
    logic clk_q;
    logic [3:0] idx;
    logic [15:0] frame;
    assign frame = {8'h55, i_tx_byte}; // Preamble byte ahead of the data byte
    initial begin
        o_tx = 1'b0;
        o_rx_byte = 8'h00;
        clk_q = 1'b0;
        idx = 4'hE;
    end
    always @(posedge i_clk_sys) begin
        clk_q <= i_bit_clk.val;
        if (!i_bit_clk.oe) begin
            o_tx <= frame[15]; // First bit ready before the state is reached
            idx <= 4'hE;
        end else if (clk_q && !i_bit_clk.val) begin
            o_tx <= frame[idx];
            idx <= idx - 4'h1;
        end
        if (!clk_q && i_bit_clk.val) begin
            o_rx_byte <= {o_rx_byte[6:0], i_rx.oe ? i_rx.val : ~o_rx_byte[0]};
        end
    end
endmodule : sport_host_model

//--- sim/tb_top.sv
/*
 * Self-checking bench for the sport serial data port.
 * Assumes the design package, the host model and the bound monitor.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sport_pkg::*;
    logic i_clk_sys, i_rst, i_ce, i_tx_serial, i_aux, i_rx_bit;
    logic i_preamble_det, i_sync_det, i_pkt_tx_bit;
    logic o_xtal_clk, o_mod_bit, o_sport_active, o_cmd_done, o_irq_general;
    logic [7:0] i_irq_src0, i_irq_src1, o_rdata, host_rx;
    reg_req_s i_req;
    pin_drive_s o_rx_serial, o_bit_clk, o_detect, o_aux;
    int fail_count, total_checks;

    sport_port sport_port_i (.i_clk_sys, .i_rst, .i_ce, .i_req, .o_rdata, .i_tx_serial,
        .i_aux, .i_rx_bit, .i_preamble_det, .i_sync_det, .i_pkt_tx_bit, .i_irq_src0,
        .i_irq_src1, .o_rx_serial, .o_bit_clk, .o_detect, .o_aux, .o_xtal_clk,
        .o_mod_bit, .o_sport_active, .o_cmd_done, .o_irq_general);
    sport_host_model sport_host_model_i (.i_clk_sys, .i_bit_clk(o_bit_clk),
        .i_rx(o_rx_serial), .i_tx_byte(8'h71), .o_tx(i_tx_serial), .o_rx_byte(host_rx));

    task automatic tally_and_finish;
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge i_clk_sys);
        i_req.we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge i_clk_sys);
        i_req.re <= 1'b0;
        @(negedge i_clk_sys);
        chk(o_rdata, exp);
    endtask : rd

    task automatic pulse(input logic sync);
        @(posedge i_clk_sys);
        i_preamble_det <= !sync;
        i_sync_det <= sync;
        @(posedge i_clk_sys);
        i_preamble_det <= 1'b0;
        i_sync_det <= 1'b0;
    endtask : pulse

    task automatic t_regs;
        rd(ADDR_DATA_PATH_CTRL, RST_DATA_PATH_CTRL);
        rd(ADDR_PIN_FUNC_CFG, RST_PIN_FUNC_CFG);
        wr(ADDR_PIN_FUNC_CFG, 8'hA5);
        rd(ADDR_PIN_FUNC_CFG, 8'hA5);
        rd(10'h000, 8'h00);
    endtask : t_regs

    task automatic t_irq(input logic [7:0] c, s0, s1, input logic e);
        wr(ADDR_DATA_PATH_CTRL, c);
        i_irq_src0 <= s0;
        i_irq_src1 <= s1;
        i_pkt_tx_bit <= s1[0];
        @(negedge i_clk_sys);
        chk(o_irq_general, e);
        chk(o_sport_active, c != 8'h00);
        if (c == 8'h00) chk(o_mod_bit, s1[0]);
    endtask : t_irq

    task automatic t_tx(input logic g);
        logic q[$];
        logic prev;
        logic due;
        int lag;
        int n;
        lag = g ? 2 : 0;
        wr(ADDR_MOD_CFG, {7'h00, g});
        wr(ADDR_DATA_PATH_CTRL, 8'h01);
        wr(ADDR_RADIO_STATE, {6'h00, CMD_TX});
        @(negedge i_clk_sys);
        chk(o_cmd_done, 1'b1);
        chk(o_bit_clk.oe, 1'b1);
        rd(ADDR_STATUS, {2'h0, CMD_TX, 4'h1});
        rd(ADDR_RADIO_STATE, {6'h00, CMD_TX});
        prev = o_bit_clk.val;
        due = 1'b0;
        n = 0;
        while (q.size() < 16 && n < 200) begin
            @(negedge i_clk_sys);
            n++;
            if (due && q.size() > lag) chk(o_mod_bit, q[q.size() - 1 - lag]);
            due = 1'b0;
            if (o_bit_clk.val && !prev) begin
                q.push_back(i_tx_serial);
                due = 1'b1;
            end
            prev = o_bit_clk.val;
        end
        chk(8'(q.size()), 8'h10);
        wr(ADDR_RADIO_STATE, {6'h00, CMD_ON});
        @(negedge i_clk_sys);
        chk(o_bit_clk.oe, 1'b0);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, {2'h0, CMD_ON, 4'h0});
    endtask : t_tx

    task automatic t_rx(input logic [7:0] cfg, input logic [1:0] mode);
        int k;
        int h;
        k = int'(cfg - 8'hA0) % 3;
        wr(ADDR_DATA_PATH_CTRL, {6'h00, mode});
        wr(ADDR_PIN_FUNC_CFG, cfg);
        wr(ADDR_RADIO_STATE, {6'h00, CMD_RX});
        i_aux <= 1'b1;
        i_rx_bit <= 1'b1;
        repeat (4) @(negedge i_clk_sys);
        chk(o_bit_clk.oe, 1'b1);
        chk(o_rx_serial.oe, k == 0);
        chk(o_detect.oe, k != 0);
        chk(o_aux.oe, cfg >= 8'hA6);
        chk(o_xtal_clk, cfg >= 8'hA3 && cfg < 8'hA6);
        pulse(1'b0);
        repeat (12) @(negedge i_clk_sys);
        chk(o_rx_serial.oe, 1'b1);
        chk(o_rx_serial.val, 1'b1);
        if (k == 1 || mode == 2) chk(o_detect.val, mode == 1);
        pulse(1'b1);
        if (k == 2) begin
            h = 0;
            while (o_detect.val === 1'b1 && h < 80) begin
                @(negedge i_clk_sys);
                h++;
            end
            while (o_detect.val !== 1'b1 && h < 80) begin
                @(negedge i_clk_sys);
                h++;
            end
            h = 0;
            while (o_detect.val === 1'b1 && h < 80) begin
                @(negedge i_clk_sys);
                h++;
            end
            chk(8'(h), 8'h08);
            while (o_detect.val !== 1'b1 && h < 80) begin
                @(negedge i_clk_sys);
                h++;
            end
            chk(8'(h), 8'h40);
        end
        repeat (72) @(negedge i_clk_sys);
        chk(host_rx, 8'hFF);
        if (k == 1) chk(o_detect.val, 1'b1);
        wr(ADDR_RADIO_STATE, {6'h00, CMD_ON});
        repeat (2) @(negedge i_clk_sys);
        chk(o_rx_serial.oe, 1'b0);
        chk(o_detect.val, 1'b0);
    endtask : t_rx

    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        i_rst = 1'b1;
        i_ce = 1'b1;
        i_req = '0;
        {i_aux, i_rx_bit, i_preamble_det, i_sync_det, i_pkt_tx_bit} = 5'h00;
        i_irq_src0 = 8'h00;
        i_irq_src1 = 8'h00;
        fail_count = 0;
        total_checks = 0;
        repeat (8) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_regs();
        t_irq(8'h02, 8'hFC, 8'h00, 1'b0);
        t_irq(8'h01, 8'h02, 8'h00, 1'b1);
        t_irq(8'h02, 8'h00, 8'h80, 1'b1);
        t_irq(8'h00, 8'hFC, 8'h00, 1'b1);
        t_irq(8'h00, 8'h00, 8'h01, 1'b1);
        t_irq(8'h00, 8'h00, 8'h00, 1'b0);
        t_tx(1'b0);
        t_tx(1'b1);
        for (int c = 8'hA0; c <= 8'hA8; c++) begin
            t_rx(8'(c), c[0] ? 2'h2 : 2'h1);
        end
        tally_and_finish();
    end
endmodule : tb_top
